// *** hdl/fss_startup_seq.sv ***
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "fss_consts.svh"
module fss_startup_seq (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        cfg_loaded,
    input  wire logic        cfg_clock_tick,
    input  wire logic        user_clock_source,
    input  wire logic        test_clock_source,
    input  wire logic        done_pin_in,
    output logic             done_pin_out,
    output logic             done_pin_oe,
    input  wire logic        clock_manager_locked,
    input  wire logic        controlled_impedance_match,
    input  wire logic        mode_select_pin_0,
    input  wire logic        mode_select_pin_1,
    input  wire logic        mode_select_pin_2,
    input  wire logic        frame_done,
    input  wire logic        frame_crc_ok,
    input  wire logic [31:0] frame_address,
    output logic             global_io_tristate,
    output logic             global_write_enable,
    output logic             block_memory_enable,
    output logic             clock_manager_reset,
    output logic             readback_allowed,
    output logic             partial_reconfig_allowed,
    output logic             parallel_config_port_reserved,
    output logic [4:0]       config_clock_rate,
    output logic [2:0]       config_mode
);

    logic [31:0] ctrl_reg;
    logic [31:0] phase_reg;
    logic [31:0] user_identity_code_reg;
    logic [11:0] keyseq_reg;
    logic [31:0] debug_output_register_reg;
    logic [5:0]  debug_zero_cnt_reg;
    logic [7:0]  last_cmd_reg;
    logic        crc_err_reg;
    logic        mfwrite_reg;
    logic [2:0]  phase_reg_cnt;
    fss_pkg::fss_state_t state_reg;
    logic        done_reg;
    logic        done_pipe_reg;
    logic        gts_reg;
    logic        gwe_reg;
    logic        mgr_rst_reg;
    logic [2:0]  mode_reg;
    logic [1:0]  mode_wait_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;

    // Two-stage synchronisers for all asynchronous inputs
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] sync_in;
    assign sync_in = {mode_select_pin_2, mode_select_pin_1, mode_select_pin_0,
                      controlled_impedance_match, clock_manager_locked, done_pin_in,
                      test_clock_source, user_clock_source};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else begin
            sync1_reg <= sync_in;
            sync2_reg <= sync1_reg;
        end
    end

    logic user_clk_s;
    logic test_clk_s;
    logic done_pin_s;
    logic locked_s;
    logic match_s;
    assign user_clk_s = sync2_reg[0];
    assign test_clk_s = sync2_reg[1];
    assign done_pin_s = sync2_reg[2];
    assign locked_s   = sync2_reg[3];
    assign match_s    = sync2_reg[4];

    // Edge detect of slow startup clocks, read only after the second stage
    logic user_clk_d_reg;
    logic test_clk_d_reg;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            user_clk_d_reg <= 1'b0;
            test_clk_d_reg <= 1'b0;
        end else begin
            user_clk_d_reg <= user_clk_s;
            test_clk_d_reg <= test_clk_s;
        end
    end

    // Startup clock enable from the selected source
    logic startup_tick;
    always_comb begin
        case (fss_pkg::fss_clk_sel_t'(ctrl_reg[`FSS_CTL_CLK_LO +: 2]))
            fss_pkg::FSS_CLK_CFG:  startup_tick = cfg_clock_tick;
            fss_pkg::FSS_CLK_USER: startup_tick = user_clk_s & ~user_clk_d_reg;
            fss_pkg::FSS_CLK_TEST: startup_tick = test_clk_s & ~test_clk_d_reg;
            default:               startup_tick = cfg_clock_tick;
        endcase
    end

    // Decoded phase match shared by done, tristate, write enable and the lock and match waits
    function automatic logic phase_hit(input logic [3:0] code, input logic [2:0] ph);
        phase_hit = (code <= 4'h6) && (code[2:0] == ph);
    endfunction

    logic [3:0] done_code;
    logic [3:0] gts_code;
    logic [3:0] gwe_code;
    logic [3:0] lck_code;
    logic [3:0] match_code;
    assign done_code  = phase_reg[`FSS_PH_DONE_LO +: 4];
    assign gts_code   = phase_reg[`FSS_PH_GTS_LO +: 4];
    assign gwe_code   = phase_reg[`FSS_PH_GWE_LO +: 4];
    assign lck_code   = phase_reg[`FSS_PH_LCK_LO +: 4];
    assign match_code = phase_reg[`FSS_PH_MATCH_LO +: 4];

    logic done_pipe_en;
    assign done_pipe_en = ctrl_reg[`FSS_CTL_DONE_PIPELINE_OPTION];

    // Qualified done: pin itself or one startup clock later
    logic qualified_done_input;
    assign qualified_done_input = done_pipe_en ? done_pipe_reg : done_pin_s;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            done_pipe_reg <= 1'b0;
        end else if (startup_tick) begin
            done_pipe_reg <= done_pin_s;
        end
    end

    // Stall while a selected wait condition for this phase is unmet
    logic stall;
    assign stall = (phase_hit(lck_code, phase_reg_cnt) && !locked_s)
                 || (phase_hit(match_code, phase_reg_cnt) && !match_s);

    // Phase sequencer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg     <= fss_pkg::FSS_ST_IDLE;
            phase_reg_cnt <= 3'h0;
        end else begin
            case (state_reg)
                fss_pkg::FSS_ST_IDLE: begin
                    phase_reg_cnt <= 3'h0;
                    if (cfg_loaded && ctrl_reg[`FSS_CTL_START]) begin
                        state_reg <= fss_pkg::FSS_ST_RUN;
                    end
                end
                fss_pkg::FSS_ST_RUN: begin
                    if (startup_tick && !stall) begin
                        if (phase_reg_cnt == `FSS_LAST_PHASE) begin
                            state_reg <= fss_pkg::FSS_ST_WAIT;
                        end else begin
                            phase_reg_cnt <= phase_reg_cnt + 3'h1;
                        end
                    end
                end
                fss_pkg::FSS_ST_WAIT: begin
                    // Pipelined done needs the pin high then one more edge
                    if (!done_pipe_en || (startup_tick && done_pipe_reg)) begin
                        state_reg <= fss_pkg::FSS_ST_DONE;
                    end
                end
                fss_pkg::FSS_ST_DONE: begin
                    state_reg <= fss_pkg::FSS_ST_DONE;
                end
                default: state_reg <= fss_pkg::FSS_ST_IDLE;
            endcase
        end
    end

    logic running;
    assign running = (state_reg == fss_pkg::FSS_ST_RUN) && startup_tick && !stall;

    // Done output at its phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            done_reg <= 1'b0;
        end else if (running && phase_hit(done_code, phase_reg_cnt)) begin
            done_reg <= 1'b1;
        end
    end

    // Tristate release: phase, qualified done, or keep
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gts_reg <= 1'b1;
        end else if (gts_code == `FSS_CODE_DONE) begin
            if (state_reg != fss_pkg::FSS_ST_IDLE && qualified_done_input) begin
                gts_reg <= 1'b0;
            end
        end else if (running && phase_hit(gts_code, phase_reg_cnt)) begin
            gts_reg <= 1'b0;
        end
    end

    // Write enable: phase, qualified done, or keep
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gwe_reg <= 1'b0;
        end else if (gwe_code == `FSS_CODE_DONE) begin
            if (state_reg != fss_pkg::FSS_ST_IDLE && qualified_done_input) begin
                gwe_reg <= 1'b1;
            end
        end else if (running && phase_hit(gwe_code, phase_reg_cnt)) begin
            gwe_reg <= 1'b1;
        end
    end

    assign global_io_tristate  = gts_reg;
    assign global_write_enable = gwe_reg;
    assign block_memory_enable = gwe_reg;

    // Done pin: open drain low until done, actively high if enabled
    assign done_pin_out = done_reg;
    assign done_pin_oe  = done_reg ? ctrl_reg[`FSS_CTL_DRIVE] : 1'b1;

    // APB write strobe, access phase
    logic apb_wr;
    assign apb_wr = psel && penable && pwrite;

    // Clock manager reset after command_a then global-high commands
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mgr_rst_reg <= 1'b0;
        end else if (apb_wr && paddr == `FSS_OFF_CMD) begin
            mgr_rst_reg <= ctrl_reg[`FSS_CTL_MGRRST] && last_cmd_reg == `FSS_CMD_COMMAND_A
                           && pwdata[7:0] == `FSS_CMD_GHIGH;
        end
    end
    assign clock_manager_reset = mgr_rst_reg;

    // Security and persistence gating
    fss_pkg::fss_sec_t sec_level;
    assign sec_level = fss_pkg::fss_sec_t'(ctrl_reg[`FSS_CTL_SEC_LO +: 2]);
    assign readback_allowed = (sec_level == fss_pkg::FSS_SEC_NONE);
    assign partial_reconfig_allowed = (sec_level != fss_pkg::FSS_SEC_LVL2);
    assign parallel_config_port_reserved = (state_reg != fss_pkg::FSS_ST_DONE)
                                         || ctrl_reg[`FSS_CTL_PERSIST];

    // Rate index: only index 0 maps to a nominal rate (4); all other indices give 0
    logic [4:0] rate_idx;
    assign rate_idx = ctrl_reg[`FSS_CTL_RATE_LO +: 5];
    always_comb begin
        case (rate_idx)
            5'h00: config_clock_rate = 5'h04;
            default: config_clock_rate = 5'h00;
        endcase
    end

    // Mode pins settle at third edge after reset, once both sync stages hold them
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_reg      <= 3'h0;
            mode_wait_reg <= 2'h0;
        end else if (mode_wait_reg != 2'h3) begin
            mode_reg      <= sync2_reg[7:5];
            mode_wait_reg <= mode_wait_reg + 2'h1;
        end
    end
    assign config_mode = mode_reg;

    // APB address decode

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == `FSS_OFF_CTRL) || (a == `FSS_OFF_PHASE) || (a == `FSS_OFF_STATUS)
                || (a == `FSS_OFF_USER_IDENTITY_CODE) || (a == `FSS_OFF_KEYSEQ) || (a == `FSS_OFF_CMD)
                || (a == `FSS_OFF_DEBUG);
    endfunction

    // Software-written configuration
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg               <= `FSS_CTL_RESET;
            phase_reg              <= `FSS_PH_RESET;
            user_identity_code_reg <= 32'h0000_0000;
            keyseq_reg             <= 12'h000;
            last_cmd_reg           <= 8'h00;
        end else if (apb_wr) begin
            case (paddr)
                `FSS_OFF_CTRL:   ctrl_reg <= {15'h0000, pwdata[16:0]};
                `FSS_OFF_PHASE:  phase_reg <= {12'h000, pwdata[19:0]};
                `FSS_OFF_USER_IDENTITY_CODE: user_identity_code_reg <= pwdata;
                `FSS_OFF_KEYSEQ: keyseq_reg <= pwdata[11:0];
                `FSS_OFF_CMD:    last_cmd_reg <= pwdata[7:0];
                default:         ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // Multiple-frame write mode latched from command
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mfwrite_reg <= 1'b0;
        end else if (apb_wr && paddr == `FSS_OFF_CMD) begin
            mfwrite_reg <= (pwdata[7:0] == `FSS_CMD_MFWRITE) || ctrl_reg[`FSS_CTL_COMPRESS];
        end
    end

    // Debug load: zeros after sync, then frame address per frame
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            debug_output_register_reg <= 32'h0000_0000;
            debug_zero_cnt_reg        <= 6'd0;
            crc_err_reg               <= 1'b0;
        end else if (ctrl_reg[`FSS_CTL_DEBUG]) begin
            if (debug_zero_cnt_reg != `FSS_DEBUG_ZEROS) begin
                debug_output_register_reg <= 32'h0000_0000;
                debug_zero_cnt_reg        <= debug_zero_cnt_reg + 6'd1;
            end else if (frame_done) begin
                debug_output_register_reg <= frame_address;
                crc_err_reg <= crc_err_reg | ~frame_crc_ok;    // set wins, sticky
            end
        end
    end

    // Read mux, one-cycle access phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_reg  <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `FSS_OFF_CTRL:   prdata_reg <= ctrl_reg;
                `FSS_OFF_PHASE:  prdata_reg <= phase_reg;
                `FSS_OFF_STATUS: prdata_reg <= {18'h00000, mfwrite_reg, crc_err_reg, mode_reg,
                                               gwe_reg, gts_reg, done_reg, state_reg, phase_reg_cnt,
                                               1'b0};
                `FSS_OFF_USER_IDENTITY_CODE: prdata_reg <= readback_allowed ? user_identity_code_reg : 32'h0000_0000;
                `FSS_OFF_KEYSEQ: prdata_reg <= {20'h00000, keyseq_reg};
                `FSS_OFF_CMD:    prdata_reg <= {24'h000000, last_cmd_reg};
                `FSS_OFF_DEBUG:  prdata_reg <= debug_output_register_reg;
                default:         prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_reg <= !addr_ok(paddr);
        end
    end

    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = psel && penable && pslverr_reg;

endmodule

// *** include/fss_consts.svh ***
`ifndef FSS_CONSTS_SVH
`define FSS_CONSTS_SVH

// APB register byte offsets
`define FSS_OFF_CTRL      12'h000
`define FSS_OFF_PHASE     12'h004
`define FSS_OFF_STATUS    12'h008
`define FSS_OFF_USER_IDENTITY_CODE    12'h00c
`define FSS_OFF_KEYSEQ    12'h010
`define FSS_OFF_CMD       12'h014
`define FSS_OFF_DEBUG     12'h018

// Control register fields
`define FSS_CTL_START      0
`define FSS_CTL_DONE_PIPELINE_OPTION   1
`define FSS_CTL_DRIVE      2
`define FSS_CTL_MGRRST     3
`define FSS_CTL_PERSIST    4
`define FSS_CTL_DEBUG      5
`define FSS_CTL_COMPRESS   6
`define FSS_CTL_KEYSTART   7
`define FSS_CTL_SEC_LO     8
`define FSS_CTL_CLK_LO     10
`define FSS_CTL_RATE_LO    12
`define FSS_CTL_RESET      32'h0000_0000

// Phase register fields, 4-bit codes each
`define FSS_PH_DONE_LO     0
`define FSS_PH_GTS_LO      4
`define FSS_PH_GWE_LO      8
`define FSS_PH_LCK_LO      12
`define FSS_PH_MATCH_LO    16
`define FSS_PH_RESET       32'h0007_7654

// Phase codes: 0..6 are phases, 7 means done/no-wait, 8 means keep
`define FSS_CODE_DONE      4'h7
`define FSS_CODE_NOWAIT    4'h7
`define FSS_CODE_KEEP      4'h8
`define FSS_LAST_PHASE     3'h7

// Command register values
`define FSS_CMD_COMMAND_A   8'h0b
`define FSS_CMD_GHIGH      8'h08
`define FSS_CMD_MFWRITE    8'h02

// Rate table size, debug zero word count
`define FSS_RATE_COUNT     17
`define FSS_DEBUG_ZEROS    6'd32

`endif

// *** include/fss_pkg.sv ***
package fss_pkg;
    typedef enum logic [1:0] {
        FSS_CLK_CFG  = 2'b00,
        FSS_CLK_USER = 2'b01,
        FSS_CLK_TEST = 2'b10
    } fss_clk_sel_t;

    typedef enum logic [1:0] {
        FSS_SEC_NONE = 2'b00,
        FSS_SEC_LVL1 = 2'b01,
        FSS_SEC_LVL2 = 2'b10
    } fss_sec_t;

    typedef enum logic [1:0] {
        FSS_KEY_SINGLE = 2'b00,
        FSS_KEY_FIRST  = 2'b01,
        FSS_KEY_MIDDLE = 2'b10,
        FSS_KEY_LAST   = 2'b11
    } fss_keyseq_t;

    typedef enum logic [1:0] {
        FSS_ST_IDLE = 2'b00,
        FSS_ST_RUN  = 2'b01,
        FSS_ST_WAIT = 2'b10,
        FSS_ST_DONE = 2'b11
    } fss_state_t;
endpackage

// *** testbench/fss_cfg_source_model.sv ***
`timescale 1ns/1ps
module fss_cfg_source_model (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic lock_req,
    input  wire logic match_req,
    output logic      cfg_clock_tick,
    output logic      clock_manager_locked,
    output logic      controlled_impedance_match
);
    logic [1:0] div_reg;
    logic [2:0] lock_reg;

    // Internal config clock as an enable every fourth cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end
    assign cfg_clock_tick = (div_reg == 2'h3);

    // Managers lock slowly, six cycles after the request
    always_ff @(posedge clk_sys) begin
        if (!lock_req) begin
            lock_reg <= 3'h0;
        end else if (lock_reg != 3'h6) begin
            lock_reg <= lock_reg + 3'h1;
        end
    end
    assign clock_manager_locked = lock_req && (lock_reg == 3'h6);
    // Impedance match answers at once
    assign controlled_impedance_match = match_req;
endmodule

// *** testbench/fss_startup_seq_checker.sv ***
`timescale 1ns/1ps
`include "fss_consts.svh"
module fss_startup_seq_checker (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        done_pin_out,
    input wire logic        done_pin_oe,
    input wire logic        global_io_tristate,
    input wire logic        global_write_enable,
    input wire logic        block_memory_enable,
    input wire logic        clock_manager_reset,
    input wire logic        readback_allowed,
    input wire logic        partial_reconfig_allowed,
    input wire logic [4:0]  config_clock_rate,
    input wire logic [2:0]  config_mode,
    input wire logic        mode_select_pin_0,
    input wire logic        mode_select_pin_1,
    input wire logic        mode_select_pin_2
);
    logic [1:0] sec_reg;
    logic [4:0] rate_reg;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Shadow of control fields; updates on the same edge as the block's own copy
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sec_reg  <= 2'h0;
            rate_reg <= 5'h00;
        end else if (psel && penable && pwrite && paddr == `FSS_OFF_CTRL) begin
            sec_reg  <= pwdata[9:8];
            rate_reg <= pwdata[16:12];
        end
    end

    // Error response for unaligned or unmapped addresses
    AST_SLVERR: assert property (psel && penable |-> pslverr == (paddr >= 12'h01c || paddr[1:0] != 2'h0))
        else $error("slave error does not match address map");
    AST_BLOCK_MEMORY_GATED: assert property (!global_write_enable |-> !block_memory_enable)
        else $error("block memory enabled before write enable");
    AST_RESET_GLOBALS: assert property ($fell(rst) |-> global_io_tristate && !global_write_enable)
        else $error("globals not in reset state");
    AST_RESET_DONE_PIN: assert property ($fell(rst) |-> done_pin_oe && !done_pin_out)
        else $error("done pin not held low after reset");
    AST_READBACK_LVL: assert property (readback_allowed == (sec_reg == 2'h0))
        else $error("readback permission wrong for level");
    AST_PARTIAL_LVL: assert property (sec_reg == 2'h2 |-> !partial_reconfig_allowed)
        else $error("partial reconfig allowed at level two");
    AST_RATE: assert property (rate_reg == 5'h00 |-> config_clock_rate == 5'h04)
        else $error("default config clock rate wrong");
    AST_GWE_HOLDS: assert property (global_write_enable |=> global_write_enable)
        else $error("write enable dropped without reset");
    AST_MODE_CAPTURE: assert property ($fell(rst) |-> ##4
        config_mode == {mode_select_pin_2, mode_select_pin_1, mode_select_pin_0})
        else $error("mode pins not captured");

    // Main scenarios reached
    cover property ($fell(global_io_tristate));
    cover property ($rose(global_write_enable));
    cover property (clock_manager_reset);
    cover property (psel && penable && pslverr);
endmodule

bind fss_startup_seq fss_startup_seq_checker i_chk (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .done_pin_out,
    .done_pin_oe, .global_io_tristate, .global_write_enable, .block_memory_enable,
    .clock_manager_reset, .readback_allowed, .partial_reconfig_allowed, .config_clock_rate,
    .config_mode, .mode_select_pin_0, .mode_select_pin_1, .mode_select_pin_2
);

// *** testbench/fss_startup_seq_tb.sv ***
`timescale 1ns/1ps
`include "fss_consts.svh"
module fss_startup_seq_tb;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        cfg_loaded = 1'b0;
    logic        lock_req = 1'b0;
    logic        match_req = 1'b0;
    logic [2:0]  mode_pins = 3'h5;
    logic [31:0] prdata;
    logic [4:0]  config_clock_rate;
    logic [2:0]  config_mode;
    logic        pready, pslverr, done_pin_in, done_pin_out, done_pin_oe, cfg_clock_tick;
    logic        locked, matched, global_io_tristate, global_write_enable, block_memory_enable;
    logic        clock_manager_reset, readback_allowed, partial_reconfig_allowed, reserved;
    int          bad_count = 0;
    int          total_checks = 0;

    // Done wire has a pull-up; the block pulls it low, and drives it high only when the drive bit is set
    assign done_pin_in = done_pin_oe ? done_pin_out : 1'b1;

    fss_cfg_source_model i_fss_cfg_source_model (.clk_sys, .rst, .lock_req, .match_req, .cfg_clock_tick,
        .clock_manager_locked(locked), .controlled_impedance_match(matched));

    fss_startup_seq i_fss_startup_seq (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .cfg_loaded, .cfg_clock_tick, .user_clock_source(1'b0),
        .test_clock_source(1'b0), .done_pin_in, .done_pin_out, .done_pin_oe,
        .clock_manager_locked(locked), .controlled_impedance_match(matched),
        .mode_select_pin_0(mode_pins[0]), .mode_select_pin_1(mode_pins[1]),
        .mode_select_pin_2(mode_pins[2]), .frame_done(1'b0), .frame_crc_ok(1'b0),
        .frame_address(32'h0000_0000), .global_io_tristate, .global_write_enable,
        .block_memory_enable, .clock_manager_reset, .readback_allowed, .partial_reconfig_allowed,
        .parallel_config_port_reserved(reserved), .config_clock_rate, .config_mode);

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    // One APB transfer; waits on pready under a bound
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        rst <= 1'b1;
        cfg_loaded <= 1'b0;
        lock_req <= 1'b0;
        match_req <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
    endtask

    // Tick index at which done, tristate release and write enable first show
    task automatic watch(output int i_d, output int i_t, output int i_w);
        int tk;
        tk = 0;
        i_d = -1;
        i_t = -1;
        i_w = -1;
        repeat (300) begin
            @(posedge clk_sys);
            tk += int'(cfg_clock_tick === 1'b1);
            if (i_d < 0 && done_pin_oe === 1'b0) i_d = tk;
            if (i_t < 0 && global_io_tristate === 1'b0) i_t = tk;
            if (i_w < 0 && global_write_enable === 1'b1) i_w = tk;
        end
    endtask

    task automatic run_start(input logic [31:0] ph, input logic [31:0] ct, output int d, output int t, output int w);
        wr(`FSS_OFF_PHASE, ph);
        wr(`FSS_OFF_CTRL, ct | 32'h1);
        cfg_loaded <= 1'b1;
        watch(d, t, w);
    endtask

    task automatic t_reset_values();
        logic [31:0] r;
        logic        e;
        do_reset();
        apb(`FSS_OFF_PHASE, 1'b0, 32'h0, r, e);
        chk("phase reset", 32'h0007_7654, r);
        apb(`FSS_OFF_CTRL, 1'b0, 32'h0, r, e);
        chk("ctrl reset", 32'h0, r);
        chk("mode", {29'h0, mode_pins}, {29'h0, config_mode});
        chk("rate", 32'h4, {27'h0, config_clock_rate});
        apb(12'h01c, 1'b0, 32'h0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        $display("Test reset_values done");
    endtask

    // Default phases and phases 1..3: one step apart, three ticks earlier
    task automatic t_phase_order();
        logic [31:0] ph [2] = '{32'h0007_7654, 32'h0007_7321};
        int d [2];
        int t;
        int w;
        for (int k = 0; k < 2; k++) begin
            do_reset();
            run_start(ph[k], 32'h0, d[k], t, w);
            chk("tristate step", 32'h1, 32'(t - d[k]));
            chk("gwe step", 32'h1, 32'(w - t));
            chk("done high", 32'h1, {31'h0, done_pin_in});
        end
        chk("done phase", 32'h3, 32'(d[0] - d[1]));
        $display("Test phase_order done");
    endtask

    // Lock wait then impedance wait at phase 2
    task automatic t_stall();
        int d;
        int t;
        int w;
        for (int k = 0; k < 2; k++) begin
            do_reset();
            run_start(k == 0 ? 32'h0007_2654 : 32'h0002_7654, 32'h0, d, t, w);
            chk("stalled", 32'hffff_ffff, 32'(d));
            lock_req <= (k == 0);
            match_req <= (k == 1);
            watch(d, t, w);
            chk("resumed", 32'h1, 32'(t - d));
        end
        $display("Test stall done");
    endtask

    // Tristate on done, write enable kept; then pipelined active drive
    task automatic t_keep_drive();
        int d;
        int t;
        int w;
        do_reset();
        run_start(32'h0007_7874, 32'h0, d, t, w);
        chk("gwe kept", 32'hffff_ffff, 32'(w));
        chk("block_memory off", 32'h0, {31'h0, block_memory_enable});
        chk("ts on done", 32'h1, 32'(d >= 0 && t >= d && t <= d + 1));
        do_reset();
        run_start(32'h0007_7654, 32'h6, d, t, w);
        chk("drive oe", 32'h1, {31'h0, done_pin_oe});
        chk("drive out", 32'h1, {31'h0, done_pin_out});
        chk("released", 32'h0, {31'h0, reserved});
        $display("Test keep_drive done");
    endtask

    task automatic t_mgr_reset();
        for (int k = 0; k < 2; k++) begin
            do_reset();
            wr(`FSS_OFF_CTRL, k == 1 ? 32'h8 : 32'h0);
            wr(`FSS_OFF_CMD, {24'h0, `FSS_CMD_COMMAND_A});
            wr(`FSS_OFF_CMD, {24'h0, `FSS_CMD_GHIGH});
            @(posedge clk_sys);
            chk("mgr reset", 32'(k), {31'h0, clock_manager_reset});
        end
        $display("Test mgr_reset done");
    endtask

    task automatic t_security();
        logic [31:0] r;
        logic        e;
        do_reset();
        wr(`FSS_OFF_USER_IDENTITY_CODE, 32'h1234_abcd);
        for (int s = 0; s < 3; s++) begin
            wr(`FSS_OFF_CTRL, (32'(s) << 8) | 32'h10);
            apb(`FSS_OFF_USER_IDENTITY_CODE, 1'b0, 32'h0, r, e);
            chk("user_identity_code", s == 0 ? 32'h1234_abcd : 32'h0, r);
            chk("readback", 32'(s == 0), {31'h0, readback_allowed});
            chk("partial", 32'(s != 2), {31'h0, partial_reconfig_allowed});
            chk("reserved", 32'h1, {31'h0, reserved});
        end
        $display("Test security done");
    endtask

    initial begin
        t_reset_values();
        t_phase_order();
        t_stall();
        t_keep_drive();
        t_mgr_reset();
        t_security();
        print_verdict();
    end
endmodule
